// *** verilog/spc_pin_control.sv ***
// spc_pin_control: pin control register bank with frame-sync source steering
// assumes a one-cycle read/write strobe port; read data valid the next cycle only
//
// Functional notes
// - bits 31..14 read zero, writes ignored
// - bit 11 picks transmit frame-sync source
// - bit 10 picks receive frame-sync, drives pin
// - all fields reset to zero
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module spc_pin_control
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [spc_pkg::ADDR_W-1:0] addr,
  input wire logic [spc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [spc_pkg::DATA_W-1:0] rdata,
  input wire logic ext_tx_fs,
  input wire logic gen_tx_fs,
  input wire logic xmit_done_fs,
  input wire logic ext_rx_fs,
  input wire logic gen_rx_fs,
  output logic tx_fs,
  output logic rx_fs_out,
  output logic rx_fs_oe,
  output logic rx_fs,
  output logic tx_clock_source,
  output logic rx_clock_source,
  output logic rate_clock_input_select,
  output logic tx_framesync_polarity,
  output logic rx_framesync_polarity,
  output logic tx_clock_polarity,
  output logic rx_clock_polarity
);
  import spc_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [DATA_W-1:0] pin_control_ff;
  logic [DATA_W-1:0] rate_cfg_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_pin_control;
  logic [DATA_W-1:0] nxt_rate_cfg;
  logic [DATA_W-1:0] nxt_rdata;

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] val,
                                              input logic [DATA_W-1:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction

  wire hit_pc;
  wire hit_rc;
  assign hit_pc = addr == PIN_CONTROL_OFS;
  assign hit_rc = addr == RATE_CFG_OFS;

  // reserved bits never stored, so they read zero
  assign nxt_pin_control = (wr && hit_pc) ?
    merge(pin_control_ff, wdata, PIN_CONTROL_WMASK) : pin_control_ff;
  assign nxt_rate_cfg = (wr && hit_rc) ?
    merge(rate_cfg_ff, wdata, RATE_CFG_WMASK) : rate_cfg_ff;
  // unmapped address reads zero; data held only one cycle
  assign nxt_rdata = !rd ? '0 :
    hit_pc ? (pin_control_ff & PIN_CONTROL_WMASK) :
    hit_rc ? rate_cfg_ff : '0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_control_ff <= PIN_CONTROL_RST;
      rate_cfg_ff <= RATE_CFG_RST;
      rdata_ff <= '0;
    end
    else
    begin
      pin_control_ff <= nxt_pin_control;
      rate_cfg_ff <= nxt_rate_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // ****************************************
  // mode outputs
  // ****************************************
  assign tx_clock_source = pin_control_ff[TX_CLK_SRC_BIT];
  assign rx_clock_source = pin_control_ff[RX_CLK_SRC_BIT];
  assign rate_clock_input_select = pin_control_ff[RATE_CLK_SEL_BIT];
  assign tx_framesync_polarity = pin_control_ff[TX_FS_POL_BIT];
  assign rx_framesync_polarity = pin_control_ff[RX_FS_POL_BIT];
  assign tx_clock_polarity = pin_control_ff[TX_CLK_POL_BIT];
  assign rx_clock_polarity = pin_control_ff[RX_CLK_POL_BIT];

  // ****************************************
  // frame-sync steering
  // ****************************************
  spc_fs_if fs_sel ();
  assign fs_sel.tx_src = pin_control_ff[TX_FS_SRC_BIT];
  assign fs_sel.rx_src = pin_control_ff[RX_FS_SRC_BIT];
  assign fs_sel.gen_sel = rate_cfg_ff[FS_GEN_SEL_BIT];

  spc_fs_mux u_mux
  (
    .sel(fs_sel.mux),
    .ext_tx_fs(ext_tx_fs),
    .gen_tx_fs(gen_tx_fs),
    .xmit_done_fs(xmit_done_fs),
    .ext_rx_fs(ext_rx_fs),
    .gen_rx_fs(gen_rx_fs),
    .tx_fs(tx_fs),
    .rx_fs(rx_fs),
    .rx_fs_oe(rx_fs_oe)
  );
  assign rx_fs_out = gen_rx_fs;
endmodule

// *** verilog/spc_pkg.sv ***
// spc_pkg: constants for the pin control register block
// assumes a plain address/strobe register port, 32-bit data, 100 MHz clock
package spc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] PIN_CONTROL_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] RATE_CFG_OFS = 8'h14;
  localparam logic [DATA_W-1:0] PIN_CONTROL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RATE_CFG_RST = 32'h0000_0000;
  // writable bits: 11..7, 5, 3..0; 13..12 and 31..14 read zero
  localparam logic [DATA_W-1:0] PIN_CONTROL_WMASK = 32'h0000_0FAF;
  localparam logic [DATA_W-1:0] RATE_CFG_WMASK = 32'h0000_0001;
  localparam int TX_FS_SRC_BIT = 11;
  localparam int RX_FS_SRC_BIT = 10;
  localparam int TX_CLK_SRC_BIT = 9;
  localparam int RX_CLK_SRC_BIT = 8;
  localparam int RATE_CLK_SEL_BIT = 7;
  localparam int TX_FS_POL_BIT = 3;
  localparam int RX_FS_POL_BIT = 2;
  localparam int TX_CLK_POL_BIT = 1;
  localparam int RX_CLK_POL_BIT = 0;
  localparam int FS_GEN_SEL_BIT = 0;
endpackage

// *** verilog/spc_fs_if.sv ***
// spc_fs_if: frame-sync selection signals between the register bank and the mux
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface spc_fs_if;
  logic tx_src;
  logic rx_src;
  logic gen_sel;
  modport regs (output tx_src, output rx_src, output gen_sel);
  modport mux (input tx_src, input rx_src, input gen_sel);
endinterface

// *** verilog/spc_fs_mux.sv ***
// spc_fs_mux: chooses frame-sync sources from the mode bits
// assumes all frame-sync inputs are synchronous to clk
`timescale 1ns/1ps
module spc_fs_mux
(
  spc_fs_if.mux sel,
  input wire logic ext_tx_fs,
  input wire logic gen_tx_fs,
  input wire logic xmit_done_fs,
  input wire logic ext_rx_fs,
  input wire logic gen_rx_fs,
  output logic tx_fs,
  output logic rx_fs,
  output logic rx_fs_oe
);
  // ****************************************
  // source selection
  // ****************************************
  wire int_tx_fs;
  assign int_tx_fs = sel.gen_sel ? gen_tx_fs : xmit_done_fs;
  assign tx_fs = sel.tx_src ? int_tx_fs : ext_tx_fs;
  assign rx_fs = sel.rx_src ? gen_rx_fs : ext_rx_fs;
  assign rx_fs_oe = sel.rx_src;
endmodule

// *** dv/spc_fs_source.sv ***
// spc_fs_source: external frame-sync partner
// assumes the bench joins its pin with the device pin
`timescale 1ns/1ps
module spc_fs_source
(
  input wire logic clk,
  input wire logic rx_fs_oe,
  input wire logic rx_fs_out,
  output logic ext_tx_fs,
  output logic ext_rx_fs
);
  logic [2:0] cnt_ff = 3'h0;
  always @(posedge clk) cnt_ff <= cnt_ff + 3'h3;
  assign ext_tx_fs = cnt_ff[0];
  // lets go of the pin while the device drives it
  assign ext_rx_fs = rx_fs_oe ? rx_fs_out : cnt_ff[1];
endmodule

// *** dv/spc_pin_control_properties.sv ***
// spc_pin_control_properties: port checks
// assumes bound to spc_pin_control, one clock
`timescale 1ns/1ps
module spc_pin_control_properties
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic rd,
  input wire logic ext_tx_fs,
  input wire logic gen_tx_fs,
  input wire logic xmit_done_fs,
  input wire logic tx_fs,
  input wire logic ext_rx_fs,
  input wire logic gen_rx_fs,
  input wire logic rx_fs,
  input wire logic rx_fs_out,
  input wire logic rx_fs_oe,
  input wire logic [spc_pkg::ADDR_W-1:0] addr,
  input wire logic [spc_pkg::DATA_W-1:0] wdata,
  input wire logic [spc_pkg::DATA_W-1:0] rdata
);
  logic src_ff;
  logic gsel_ff;
  wire hit = addr == PIN_CONTROL_OFS;
  wire hit_rate = addr == RATE_CFG_OFS;
  // shadow of the transmit source bit and the generator select bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      src_ff <= 1'b0;
      gsel_ff <= 1'b0;
    end
    else
    begin
      if (wr && hit)
        src_ff <= wdata[TX_FS_SRC_BIT];
      if (wr && hit_rate)
        gsel_ff <= wdata[FS_GEN_SEL_BIT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_rd;
    wr && hit ##1 !wr ##1 rd && hit;
  endsequence
  a_upper_zero:
    assert property (rdata[31:12] == 20'h0) else $error("upper bits set");
  a_read_back:
    assert property (s_wr_rd |=> rdata == ($past(wdata, 3) & PIN_CONTROL_WMASK))
    else $error("read back differs");
  a_tx_external:
    assert property (!src_ff |-> tx_fs == ext_tx_fs) else $error("tx sync source");
  a_tx_internal:
    assert property (src_ff |-> tx_fs == (gsel_ff ? gen_tx_fs : xmit_done_fs))
    else $error("tx internal source");
  a_rx_pin_mux:
    assert property (rx_fs == (rx_fs_oe ? gen_rx_fs : ext_rx_fs) && rx_fs_out == gen_rx_fs)
    else $error("rx sync source");
  a_oe_follows:
    assert property (wr && hit |=> rx_fs_oe == $past(wdata[RX_FS_SRC_BIT]))
    else $error("pin enable");
  a_reset_clear:
    assert property (disable iff (1'b0) rst |-> rdata == 32'h0 && !rx_fs_oe)
    else $error("not cleared");
endmodule
bind spc_pin_control spc_pin_control_properties i_chk (.*);

// *** dv/tb.sv ***
// tb: self-checking bench for the pin control register
// assumes spc_pin_control, spc_fs_source and the bound checker
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import spc_pkg::*;
  logic clk = 0, rst = 0, wr = 0, rd = 0, rd_d = 0, g, ext_tx_fs, ext_rx_fs, tx_fs, rx_fs;
  logic gen_tx_fs = 0, xmit_done_fs = 0, gen_rx_fs = 0, rx_fs_oe, rx_fs_out;
  logic tx_clock_source, rx_clock_source, rate_clock_input_select, tx_framesync_polarity;
  logic rx_framesync_polarity, tx_clock_polarity, rx_clock_polarity;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata, v, rd_exp, s = 32'hE726, q[$];
  int mismatches = 0, samples_checked = 0, cyc = 0;
  always #5 clk = ~clk;
  spc_fs_source i_src (.*);
  spc_pin_control i_dut (.*);
  function automatic logic [31:0] nx(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [31:0] e);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    q.push_back(e);
    @(posedge clk) rd <= 1'b0;
  endtask
  task results();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    rd_d <= rd;
    {gen_tx_fs, xmit_done_fs, gen_rx_fs} <= s[3:1];
    if (rd_d)
    begin
      rd_exp = q.pop_front();
      `CHK(rdata, rd_exp)
    end
    if (++cyc > 3000) begin mismatches++; results(); end
  end
  initial
  begin
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(PIN_CONTROL_OFS, PIN_CONTROL_RST);
    repeat (12)
    begin
      s = nx(s);
      v = s & ~32'h3000;
      g = s[13];
      wr_reg(RATE_CFG_OFS, {31'h0, g});
      wr_reg(PIN_CONTROL_OFS, v);
      #1 `CHK({tx_clock_source, rx_clock_source, rate_clock_input_select}, v[9:7])
      `CHK({tx_framesync_polarity, rx_framesync_polarity}, v[3:2])
      `CHK({tx_clock_polarity, rx_clock_polarity, rx_fs_oe}, {v[1:0], v[10]})
      `CHK(tx_fs, v[11] ? (g ? gen_tx_fs : xmit_done_fs) : ext_tx_fs)
      `CHK({rx_fs, rx_fs_out}, {v[10] ? gen_rx_fs : ext_rx_fs, gen_rx_fs})
      rd_reg(PIN_CONTROL_OFS, v & PIN_CONTROL_WMASK);
      rd_reg(RATE_CFG_OFS, {31'h0, g});
      rd_reg(8'h30, 32'h0);
      wr_reg(8'h30, s);
    end
    rd_reg(PIN_CONTROL_OFS, v & PIN_CONTROL_WMASK);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd_reg(PIN_CONTROL_OFS, 32'h0);
    #1 `CHK({rx_fs_oe, tx_fs, rx_fs}, {1'b0, ext_tx_fs, ext_rx_fs})
    repeat (3) @(posedge clk);
    results();
  end
endmodule
